// ==== irsir_endec.v ====
// infrared serial encoder/decoder between serial_port_zero and an ir transceiver
// assumes i_baud_tick pulses once per baud-rate clock, 16 per bit, same i_clk domain
`timescale 1ns/1ps
`include "irsir_regs.vh"

// ****************
// fifo
// ****************
module irsir_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `IRSIR_FIFO_DEPTH,
  parameter AW = `IRSIR_FIFO_AW
) (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  // fill side
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  // drain side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  // full when the pointers differ only in the wrap bit
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = i_in_valid && !full;
  wire pop = !empty && i_out_ready;
  // pointers step by one; the increment is widened on purpose
  wire [AW:0] next_wr_ptr = wr_ptr + {{AW{1'b0}}, push};
  wire [AW:0] next_rd_ptr = rd_ptr + {{AW{1'b0}}, pop};
  wire next_full = (next_wr_ptr[AW] != next_rd_ptr[AW]) && (next_wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]);
  reg in_ready;
  assign o_in_ready = in_ready;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
  always @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      // ready comes from a flop so the port never glitches
      in_ready <= !next_full;
    end
  end
endmodule

// ****************
// encoder/decoder
// ****************
module irsir_endec (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  // baud-rate clock as a pulse
  input wire i_baud_tick,
  // serial port side
  input wire i_tx_valid,
  output wire o_tx_ready,
  input wire i_tx_bit,
  output reg o_rx_serial,
  input wire i_infrared_receive_enable,
  // transceiver side
  output reg o_infrared_drive_out,
  input wire i_infrared_sense_in
);
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;
  reg [1:0] state;
  reg [3:0] tx_phase;
  reg tx_cur;
  reg [3:0] rx_phase;
  reg rx_seen_pulse;
  reg rx_active;
  reg sync1;
  reg sync2;
  reg sync3;
  reg sense;
  wire fifo_valid;
  wire fifo_bit;
  // half duplex: queued bits wait while the decoder listens
  wire fifo_pop = (state == ST_IDLE) && fifo_valid && !i_infrared_receive_enable;
  // pulse slice of a zero bit, clocks 7..9 of 16
  wire tx_in_pulse = !tx_cur && (tx_phase >= `IRSIR_PULSE_START) && (tx_phase <= `IRSIR_PULSE_END);
  irsir_fifo #(
    .WIDTH(1),
    .DEPTH(`IRSIR_FIFO_DEPTH),
    .AW(`IRSIR_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_bit),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_bit)
  );
  // ****************
  // transmit
  // ****************
  // the next bit leaves the fifo once idle and waits in ST_SEND for a tick, so the 16-clock frame stays aligned
  always @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      tx_phase <= 4'h0;
      tx_cur <= 1'b1;
      o_infrared_drive_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // one idle cycle between bits to pop the next one
          o_infrared_drive_out <= 1'b0;
          tx_phase <= 4'h0;
          if (fifo_pop) begin
            tx_cur <= fifo_bit;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (i_baud_tick) begin
            // drive only moves on a tick, so every slice is whole ticks
            // a one stays dark; a zero lights only in its pulse slice
            o_infrared_drive_out <= tx_in_pulse;
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == `IRSIR_PHASE_LAST) begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ****************
  // receive
  // ****************
  // three stages; a change counts once stages two and three agree
  // stages start high, the idle level, so no false pulse follows reset
  always @(posedge i_clk) begin
    if (i_srst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      sense <= 1'b1;
    end else begin
      sync1 <= i_infrared_sense_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        sense <= sync3;
      end
    end
  end
  // a bit slot opens at the first low pulse, then runs 16 clocks
  // limitation: the decoded bit lags the air by the pulse offset of 7 ticks plus the synchronizer delay
  always @(posedge i_clk) begin
    if (i_srst) begin
      rx_phase <= 4'h0;
      rx_seen_pulse <= 1'b0;
      rx_active <= 1'b0;
      o_rx_serial <= 1'b1;
    end else if (!i_infrared_receive_enable) begin
      // decoder off: the serial line idles at one
      rx_phase <= 4'h0;
      rx_seen_pulse <= 1'b0;
      rx_active <= 1'b0;
      o_rx_serial <= 1'b1;
    end else if (i_baud_tick) begin
      if (!rx_active) begin
        if (!sense) begin
          rx_active <= 1'b1;
          rx_phase <= 4'h1;
          o_rx_serial <= 1'b0;
        end
      end else if (rx_phase == 4'h0) begin
        // sixteen ticks done; a pulse on the boundary or seen early opens the next zero
        rx_seen_pulse <= 1'b0;
        if (rx_seen_pulse || !sense) begin
          rx_phase <= 4'h1;
          o_rx_serial <= 1'b0;
        end else begin
          rx_active <= 1'b0;
          o_rx_serial <= 1'b1;
        end
      end else begin
        rx_phase <= rx_phase + 4'h1;
        // a transmitter running a little fast shows its next pulse before the boundary
        if (!sense && rx_phase > `IRSIR_PULSE_END) begin
          rx_seen_pulse <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== irsir_endec_tb_top.sv ====
// bench: tx through the fifo, rx from the model
// assumes a baud tick every 3 clocks
`timescale 1ns/1ps
module irsir_endec_tb_top;
  reg i_clk = 1'b0;
  reg i_srst = 1'b1;
  reg i_baud_tick = 1'b0;
  reg i_tx_valid = 1'b0;
  reg i_tx_bit = 1'b1;
  reg i_infrared_receive_enable = 1'b0;
  wire o_tx_ready, o_rx_serial, o_infrared_drive_out, i_infrared_sense_in;
  reg [1:0] tc = 2'h0;
  integer hi_cyc = 0, rx_hi_cyc = 0, cyc = 0, n_errors = 0, samples_checked = 0, k;
  always #25 i_clk = ~i_clk;
  irsir_endec dut (.i_clk(i_clk), .i_srst(i_srst), .i_baud_tick(i_baud_tick), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .i_tx_bit(i_tx_bit), .o_rx_serial(o_rx_serial),
    .i_infrared_receive_enable(i_infrared_receive_enable), .o_infrared_drive_out(o_infrared_drive_out),
    .i_infrared_sense_in(i_infrared_sense_in));
  irsir_xcvr_model xcvr (.i_clk(i_clk), .i_baud_tick(i_baud_tick), .o_sense(i_infrared_sense_in));
  // ****
  // tick, drive monitor, timeout
  // ****
  always @(posedge i_clk) begin
    tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
    i_baud_tick <= (tc == 2'h2);
    hi_cyc <= hi_cyc + (o_infrared_drive_out === 1'b1);
    rx_hi_cyc <= rx_hi_cyc + (o_rx_serial === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  task cmp(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task push(input b);
    i_tx_valid <= 1'b1;
    i_tx_bit <= b;
    @(negedge i_clk);
    while (o_tx_ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    i_tx_valid <= 1'b0;
    @(posedge i_clk);
  endtask
  // fill while held off, then drain: 8 zeros of 3 ticks high, 8 dark ones
  task t_tx;
    @(posedge i_clk);
    i_infrared_receive_enable <= 1'b1;
    for (k = 0; k < 16; k = k + 1) push(k[0]);
    @(negedge i_clk);
    cmp(o_tx_ready, 1'h0);
    cmp(hi_cyc, 32'h0);
    @(posedge i_clk);
    i_infrared_receive_enable <= 1'b0;
    repeat (1000) @(negedge i_clk);
    cmp(hi_cyc, 32'h48);
    cmp(o_tx_ready, 1'h1);
    $display("t_tx done");
  endtask
  // two zeros back to back must not blink high at the boundary
  task t_rx;
    integer h;
    @(posedge i_clk);
    i_infrared_receive_enable <= 1'b1;
    xcvr.send_bit(1'b0);
    h = rx_hi_cyc;
    xcvr.send_bit(1'b0);
    @(negedge i_clk);
    cmp(rx_hi_cyc - h, 32'h0);
    cmp(o_rx_serial, 1'h0);
    xcvr.send_bit(1'b1);
    @(negedge i_clk);
    cmp(o_rx_serial, 1'h1);
    $display("t_rx done");
  endtask
  task t_reset;
    cmp({o_infrared_drive_out, o_rx_serial, o_tx_ready}, 3'h3);
    $display("t_reset done");
  endtask
  task summarize;
    $display("checked=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
    t_reset;
    t_tx;
    t_rx;
    summarize;
  end
endmodule

// ==== irsir_props.sv ====
// assertions on the ir endec ports
// assumes one clock domain, sync reset
`timescale 1ns/1ps
module irsir_props (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  // watched ports
  input wire i_baud_tick,
  input wire i_infrared_receive_enable,
  input wire o_rx_serial,
  input wire o_infrared_drive_out
);
  wire t = i_baud_tick;
  wire e = i_infrared_receive_enable;
  wire r = o_rx_serial;
  wire d = o_infrared_drive_out;
  reg [4:0] hi;
  reg [4:0] lo;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ****
  // tick counts per drive level
  // ****
  // lo saturates so a long idle never wraps
  always @(posedge i_clk) begin
    hi <= (i_srst | !d) ? 5'h00 : hi + {4'h0, t};
    lo <= i_srst ? 5'h1F : d ? 5'h00 : lo + {4'h0, t & (lo != 5'h1F)};
  end
  a_drive_on_tick: assert property ($changed(d) |-> $past(t)) else $error("drive off tick");
  a_pulse_width: assert property ($fell(d) |-> hi == 5'h03) else $error("pulse width");
  a_pulse_bound: assert property (hi <= 5'h03) else $error("pulse long");
  a_pulse_gap: assert property ($rose(d) |-> lo >= 5'h0D) else $error("pulse gap");
  a_rx_off: assert property (!e |=> r) else $error("rx off");
  a_rx_fall: assert property ($fell(r) |-> $past(t) && $past(e)) else $error("rx fall");
  a_rx_rise: assert property ($rose(r) |-> $past(t) || !$past(e)) else $error("rx rise");
endmodule
bind irsir_endec irsir_props u_props (.i_clk(i_clk), .i_srst(i_srst), .i_baud_tick(i_baud_tick),
  .i_infrared_receive_enable(i_infrared_receive_enable), .o_rx_serial(o_rx_serial),
  .o_infrared_drive_out(o_infrared_drive_out));

// ==== irsir_regs.vh ====
// constants for the infrared serial encoder/decoder
// assumes a 16x baud-rate enable pulse from the serial port's rate generator
`ifndef IRSIR_REGS_VH
`define IRSIR_REGS_VH
// ****************
// bit timing
// ****************
`define IRSIR_CLKS_PER_BIT 5'd16
`define IRSIR_ZERO_LOW_HEAD 5'd7
`define IRSIR_ZERO_HIGH_LEN 5'd3
`define IRSIR_ZERO_LOW_TAIL 5'd6
`define IRSIR_PULSE_START 4'h7
`define IRSIR_PULSE_END 4'h9
`define IRSIR_PHASE_LAST 4'hF
// ****************
// buffering
// ****************
`define IRSIR_FIFO_DEPTH 16
`define IRSIR_FIFO_AW 4
`endif

// ==== irsir_xcvr_model.sv ====
// transceiver model: bits to low pulses on the sense line
// assumes the bench's baud tick
`timescale 1ns/1ps
module irsir_xcvr_model (
  // clock and tick
  input wire i_clk,
  input wire i_baud_tick,
  // sense line, idles high
  output reg o_sense
);
  // ****
  // sender
  // ****
  initial o_sense = 1'b1;
  task automatic send_bit(input b);
    integer k;
    for (k = 0; k < 16; k = k + 1) begin
      @(posedge i_clk);
      while (i_baud_tick !== 1'b1) @(posedge i_clk);
      o_sense <= b | (k < 7) | (k > 9);
    end
  endtask
endmodule
